// ===== inc/led_fault_params.svh
`ifndef LED_FAULT_PARAMS_SVH
`define LED_FAULT_PARAMS_SVH

// System clock rate
`define CLK_FREQ_KHZ 50000
// Nominal converter switching rate
`define SW_FREQ_KHZ 500
// Clock cycles per switching cycle
`define SW_DIV_CYCLES (`CLK_FREQ_KHZ / `SW_FREQ_KHZ)

// Retry wait after LED string overcurrent, in switching cycles
`define RETRY_SW_CYCLES 16000
// Persistence of LED string overcurrent before the wait starts, in switching cycles
`define OC_QUALIFY_SW_CYCLES 2

// Counter width for divider and retry timer
`define CNT_W 16

// Analog trip points, kept for reference by the comparators
`define OT_TRIP_DEGC 165
`define OT_RELEASE_DEGC 145
`define REG_SHORT_MV 1400
`define RUNAWAY_KHZ 2500

// Reset values
`define RST_DRIVE 1'b0
`define RST_FLAG_PULL 1'b0
`define RST_STANDBY 1'b1
`define RST_COMP_RESET 1'b1

`endif

// ===== inc/led_fault_pkg.sv
`include "led_fault_params.svh"

package led_fault_pkg;

	// Raw comparator outputs, all active high
	typedef struct packed {
		logic ot_hot;
		logic ot_cool;
		logic vin_undervoltage_lockout;
		logic reg_undervoltage_lockout;
		logic reg_short;
		logic output_overvoltage_protect;
		logic sw_cl;
		logic led_oc;
		logic runaway;
	} cmp_in_t;

	// Per-fault status seen by the supervisor
	typedef struct packed {
		logic thermal;
		logic vin_undervoltage_lockout;
		logic reg_undervoltage_lockout;
		logic reg_short;
		logic output_overvoltage_protect;
		logic cur_limit;
		logic led_oc;
		logic runaway;
	} fault_status_t;

	// LED string overcurrent retry sequence
	typedef enum logic [1:0] {
		LOC_IDLE,
		LOC_QUALIFY,
		LOC_SKIP
	} loc_state_t;

	// Whole state of the supervisor
	typedef struct packed {
		logic [`CNT_W-1:0] sw_cnt;
		logic sw_tick;
		logic ot_latched;
		logic cl_latched;
		loc_state_t loc;
		logic [`CNT_W-1:0] loc_cnt;
		logic switch_drive;
		logic dim_drive;
		logic standby;
		logic comp_reset;
		logic flag_pull;
		logic flag_level;
		fault_status_t status;
	} state_t;

	// State of the synchroniser
	typedef struct packed {
		cmp_in_t stage1;
		cmp_in_t stage2;
	} sync_state_t;

endpackage

// ===== rtl/comparator_sync.sv
`timescale 1ns/1ns
`default_nettype none

module comparator_sync (
	input wire logic clk,
	input wire logic rst,
	input wire led_fault_pkg::cmp_in_t raw,
	output led_fault_pkg::cmp_in_t synced
);
	import led_fault_pkg::*;

	sync_state_t st;
	sync_state_t next_st;
	logic [$bits(cmp_in_t)-1:0] raw_bits;
	logic [$bits(cmp_in_t)-1:0] s1_bits;
	logic [$bits(cmp_in_t)-1:0] s2_bits;
	logic [$bits(cmp_in_t)-1:0] next_s1;
	logic [$bits(cmp_in_t)-1:0] next_s2;

	assign raw_bits = raw;
	assign s1_bits = st.stage1;
	assign s2_bits = st.stage2;

	// Two stages per comparator bit; first stage feeds only the second
	genvar i;
	generate
		for (i = 0; i < $bits(cmp_in_t); i++) begin : g_bit
			assign next_s1[i] = raw_bits[i];
			assign next_s2[i] = s1_bits[i];
		end
	endgenerate

	// Next state assembly
	always_comb begin
		next_st = st;
		next_st.stage1 = next_s1;
		next_st.stage2 = next_s2;
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign synced = s2_bits;

endmodule

`default_nettype wire

// ===== rtl/led_driver_fault_supervisor.sv
`timescale 1ns/1ns
`default_nettype none

`include "led_fault_params.svh"

// Function
// - Over-temperature trip forces gate low, standby, compensation reset and flag low.
// - After thermal shutdown, stay off until die cools below release point.
// - Fault flag is open drain: pulled low for reported faults, else released.
// - Input undervoltage drops gate and dimming, standby, compensation reset, not reported.
// - Regulator undervoltage drops gate, standby, compensation reset, not reported.
// - Regulator short after startup: gate low, standby, compensation reset, flag low.
// - Output overvoltage: gate low, standby, compensation reset, flag low until cleared.
// - Switch current limit ends pulse until next cycle; no standby, no flag.
// - Boost LED overcurrent: drives low, compensation reset, flag low, retry after wait.
// - Frequency runaway forces gate low and flag low without standby.
// - LED overcurrent must persist two switching cycles before the wait starts.
// - Dimming stays low for the whole wait, then restart is attempted.
module led_driver_fault_supervisor #(
	parameter logic [`CNT_W-1:0] SW_DIV = `CNT_W'(`SW_DIV_CYCLES),
	parameter logic [`CNT_W-1:0] RETRY_CYCLES = `CNT_W'(`RETRY_SW_CYCLES),
	parameter logic [`CNT_W-1:0] QUALIFY_CYCLES = `CNT_W'(`OC_QUALIFY_SW_CYCLES)
) (
	input wire logic clk,
	input wire logic rst,
	input wire led_fault_pkg::cmp_in_t cmp_raw,
	input wire logic boost_mode,
	input wire logic startup_done,
	input wire logic gate_request,
	input wire logic dim_request,
	output logic switch_drive,
	output logic dim_switch_drive,
	output logic standby,
	output logic comp_reset,
	output logic fault_flag_n_o,
	output logic fault_flag_n_oe,
	output led_fault_pkg::fault_status_t fault_status
);
	import led_fault_pkg::*;

	state_t st;
	state_t next_st;
	cmp_in_t cmp;
	logic thermal_active;
	logic short_active;
	logic led_oc_active;
	logic led_skip;
	logic cl_active;
	logic gate_block;
	logic dim_block;
	logic standby_req;
	logic comp_req;
	logic flag_req;

	// Comparator inputs into the clock domain
	comparator_sync u_sync (
		.clk(clk),
		.rst(rst),
		.raw(cmp_raw),
		.synced(cmp)
	);

	// Fault conditions derived from synchronised comparators
	always_comb begin
		thermal_active = st.ot_latched | cmp.ot_hot;
		short_active = cmp.reg_short & startup_done;
		led_oc_active = cmp.led_oc & boost_mode;
		led_skip = (st.loc == LOC_SKIP);
		cl_active = cmp.sw_cl | st.cl_latched;
	end

	// Combine every fault into per-output demands
	always_comb begin
		gate_block = thermal_active | cmp.vin_undervoltage_lockout | cmp.reg_undervoltage_lockout | short_active
			| cmp.output_overvoltage_protect | cl_active | led_oc_active | led_skip | cmp.runaway;
		dim_block = cmp.vin_undervoltage_lockout | led_skip;
		standby_req = thermal_active | cmp.vin_undervoltage_lockout | cmp.reg_undervoltage_lockout
			| short_active | cmp.output_overvoltage_protect;
		comp_req = standby_req | led_skip;
		flag_req = thermal_active | short_active | cmp.output_overvoltage_protect
			| led_skip | cmp.runaway;
	end

	// Next state
	always_comb begin
		next_st = st;

		// Switching cycle enable divider
		if (st.sw_cnt == SW_DIV - `CNT_W'(1)) begin
			next_st.sw_cnt = '0;
			next_st.sw_tick = 1'b1;
		end else begin
			next_st.sw_cnt = st.sw_cnt + `CNT_W'(1);
			next_st.sw_tick = 1'b0;
		end

		// Thermal hysteresis latch, trip wins over release
		if (cmp.ot_hot) begin
			next_st.ot_latched = 1'b1;
		end else if (cmp.ot_cool) begin
			next_st.ot_latched = 1'b0;
		end

		// Pulse termination until the next switching cycle, new trip wins
		if (cmp.sw_cl) begin
			next_st.cl_latched = 1'b1;
		end else if (st.sw_tick) begin
			next_st.cl_latched = 1'b0;
		end

		// LED string overcurrent qualify and retry wait
		case (st.loc)
			LOC_IDLE: begin
				next_st.loc_cnt = '0;
				if (led_oc_active) begin
					next_st.loc = LOC_QUALIFY;
				end
			end
			LOC_QUALIFY: begin
				if (!led_oc_active) begin
					next_st.loc = LOC_IDLE;
					next_st.loc_cnt = '0;
				end else if (st.sw_tick) begin
					if (st.loc_cnt == QUALIFY_CYCLES - `CNT_W'(1)) begin
						next_st.loc = LOC_SKIP;
						next_st.loc_cnt = '0;
					end else begin
						next_st.loc_cnt = st.loc_cnt + `CNT_W'(1);
					end
				end
			end
			LOC_SKIP: begin
				if (st.sw_tick) begin
					if (st.loc_cnt == RETRY_CYCLES - `CNT_W'(1)) begin
						next_st.loc = LOC_IDLE;
						next_st.loc_cnt = '0;
					end else begin
						next_st.loc_cnt = st.loc_cnt + `CNT_W'(1);
					end
				end
			end
			default: begin
				next_st.loc = LOC_IDLE;
				next_st.loc_cnt = '0;
			end
		endcase

		// Registered outputs
		next_st.switch_drive = gate_request & ~gate_block;
		next_st.dim_drive = dim_request & ~dim_block;
		next_st.standby = standby_req;
		next_st.comp_reset = comp_req;
		next_st.flag_pull = flag_req;
		next_st.flag_level = 1'b0;

		// Status snapshot
		next_st.status.thermal = thermal_active;
		next_st.status.vin_undervoltage_lockout = cmp.vin_undervoltage_lockout;
		next_st.status.reg_undervoltage_lockout = cmp.reg_undervoltage_lockout;
		next_st.status.reg_short = short_active;
		next_st.status.output_overvoltage_protect = cmp.output_overvoltage_protect;
		next_st.status.cur_limit = cl_active;
		next_st.status.led_oc = led_skip;
		next_st.status.runaway = cmp.runaway;
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
			st.loc <= LOC_IDLE;
			st.switch_drive <= `RST_DRIVE;
			st.dim_drive <= `RST_DRIVE;
			st.standby <= `RST_STANDBY;
			st.comp_reset <= `RST_COMP_RESET;
			st.flag_pull <= `RST_FLAG_PULL;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register
	assign switch_drive = st.switch_drive;
	assign dim_switch_drive = st.dim_drive;
	assign standby = st.standby;
	assign comp_reset = st.comp_reset;
	assign fault_flag_n_o = st.flag_level;
	assign fault_flag_n_oe = st.flag_pull;
	assign fault_status = st.status;

endmodule

`default_nettype wire

// ===== verification/flag_pullup_host.sv
`timescale 1ns/1ns
`default_nettype none

module flag_pullup_host (
	input wire logic fault_flag_n_o,
	input wire logic fault_flag_n_oe,
	output logic flag_pin
);
	// Pull-up holds the pin high unless the device sinks it
	assign flag_pin = fault_flag_n_oe ? fault_flag_n_o : 1'b1;
endmodule

`default_nettype wire

// ===== verification/led_driver_fault_supervisor_props.sv
`timescale 1ns/1ns
`default_nettype none

module led_driver_fault_supervisor_props (
	input wire logic clk,
	input wire logic rst,
	input wire led_fault_pkg::cmp_in_t cmp_raw,
	input wire logic startup_done,
	input wire logic gate_request,
	input wire logic switch_drive,
	input wire logic dim_switch_drive,
	input wire logic standby,
	input wire logic comp_reset,
	input wire logic fault_flag_n_o,
	input wire logic fault_flag_n_oe,
	input wire led_fault_pkg::fault_status_t fault_status
);
	import led_fault_pkg::*;
	logic [2:0] age;
	logic rep;
	logic sb;
	// Cycles since reset release, saturating
	always_ff @(posedge clk) begin
		if (rst) begin
			age <= 3'h0;
		end else if (age != 3'h7) begin
			age <= age + 3'h1;
		end
	end
	// Reported and standby fault groups
	assign rep = fault_status.thermal | fault_status.reg_short | fault_status.output_overvoltage_protect
		| fault_status.led_oc | fault_status.runaway;
	assign sb = fault_status.thermal | fault_status.vin_undervoltage_lockout | fault_status.reg_undervoltage_lockout
		| fault_status.reg_short | fault_status.output_overvoltage_protect;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_ovp_latency: assert property (age > 3'h4 |-> fault_status.output_overvoltage_protect == $past(cmp_raw.output_overvoltage_protect, 3))
		else $error("overvoltage status latency wrong");
	chk_flag_drive: assert property (fault_flag_n_oe |-> !fault_flag_n_o)
		else $error("flag driven high");
	chk_flag_reported: assert property (fault_flag_n_oe == rep)
		else $error("flag does not match reported faults");
	chk_standby_cause: assert property (age != 3'h0 |-> standby == sb)
		else $error("standby does not match faults");
	chk_comp_reset: assert property (age != 3'h0
		|-> comp_reset == (sb | fault_status.led_oc))
		else $error("compensation reset wrong");
	chk_dim_low: assert property (fault_status.vin_undervoltage_lockout | fault_status.led_oc |-> !dim_switch_drive)
		else $error("dimming drive high in fault");
	chk_gate_low: assert property (|fault_status |-> !switch_drive)
		else $error("switch drive high in fault");
	chk_gate_cause: assert property (switch_drive |-> $past(gate_request))
		else $error("switch drive without request");
	chk_short_start: assert property (age > 3'h1 && fault_status.reg_short |-> $past(startup_done))
		else $error("regulator short before startup");
	chk_thermal_hyst: assert property (age > 3'h4 && $fell(fault_status.thermal)
		|-> $past(cmp_raw.ot_cool, 4) && !$past(cmp_raw.ot_hot, 4)
		&& !$past(cmp_raw.ot_hot, 3))
		else $error("thermal released while hot");
endmodule

bind led_driver_fault_supervisor led_driver_fault_supervisor_props u_props (.clk, .rst, .cmp_raw,
	.startup_done, .gate_request, .switch_drive, .dim_switch_drive, .standby, .comp_reset,
	.fault_flag_n_o, .fault_flag_n_oe, .fault_status);

`default_nettype wire

// ===== verification/led_driver_fault_supervisor_test.sv
`timescale 1ns/1ns
`default_nettype none

module led_driver_fault_supervisor_test;
	import led_fault_pkg::*;
	localparam logic [15:0] SW_DIV = 16'h0004;
	localparam logic [15:0] RETRY = 16'h0005;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic boost_mode = 1'b0;
	logic startup_done = 1'b0;
	logic gate_request = 1'b0;
	logic dim_request = 1'b0;
	cmp_in_t cmp_raw = '0;
	logic switch_drive, dim_switch_drive, standby, comp_reset, flag_o, flag_oe, flag_pin;
	fault_status_t fault_status;
	logic [12:0] obs;
	logic [12:0] want;
	int errors = 0;
	int comparisons = 0;
	int cycles = 0;
	int n;
	assign obs = {switch_drive, dim_switch_drive, standby, comp_reset, flag_pin, fault_status};
	led_driver_fault_supervisor #(.SW_DIV(SW_DIV), .RETRY_CYCLES(RETRY),
		.QUALIFY_CYCLES(16'h0002)) u_led_driver_fault_supervisor (.clk(clk), .rst(rst),
		.cmp_raw(cmp_raw), .boost_mode(boost_mode), .startup_done(startup_done),
		.gate_request(gate_request), .dim_request(dim_request), .switch_drive(switch_drive),
		.dim_switch_drive(dim_switch_drive), .standby(standby), .comp_reset(comp_reset),
		.fault_flag_n_o(flag_o), .fault_flag_n_oe(flag_oe), .fault_status(fault_status));
	flag_pullup_host u_flag_pullup_host (.fault_flag_n_o(flag_o), .fault_flag_n_oe(flag_oe),
		.flag_pin(flag_pin));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Steady outputs for a fault mix without current limit or boost
	function automatic logic [12:0] expect_out(cmp_in_t c, logic st, logic g, logic d);
		logic rs;
		logic sb;
		rs = c.reg_short & st;
		sb = c.ot_hot | c.vin_undervoltage_lockout | c.reg_undervoltage_lockout | rs | c.output_overvoltage_protect;
		return {g & !(sb | c.runaway), d & !c.vin_undervoltage_lockout, sb, sb,
			!(c.ot_hot | rs | c.output_overvoltage_protect | c.runaway),
			c.ot_hot, c.vin_undervoltage_lockout, c.reg_undervoltage_lockout, rs, c.output_overvoltage_protect, 2'b00, c.runaway};
	endfunction
	task automatic results();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		forever #10 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			results();
		end
	end
	initial begin
		n = $urandom(26652);
		repeat (8) @(negedge clk);
		rst = 1'b0;
		// Random fault mixes, LED overcurrent ignored outside boost
		for (int i = 0; i < 200; i++) begin
			cmp_raw = cmp_in_t'($urandom & $urandom & $urandom);
			cmp_raw.sw_cl = 1'b0;
			cmp_raw.ot_cool = !cmp_raw.ot_hot;
			{startup_done, gate_request, dim_request} = 3'($urandom);
			repeat (5) @(negedge clk);
			want = expect_out(cmp_raw, startup_done, gate_request, dim_request);
			check(16'(obs), 16'(want));
		end
		// Thermal hysteresis
		{gate_request, dim_request} = 2'b11;
		cmp_raw = '0;
		cmp_raw.ot_hot = 1'b1;
		repeat (5) @(negedge clk);
		cmp_raw.ot_hot = 1'b0;
		repeat (5) @(negedge clk);
		check(16'({standby, flag_pin, fault_status.thermal}), 16'h5);
		cmp_raw.ot_cool = 1'b1;
		repeat (5) @(negedge clk);
		check(16'({switch_drive, standby}), 16'h2);
		// One-cycle current limit pulse
		cmp_raw.sw_cl = 1'b1;
		@(negedge clk);
		cmp_raw.sw_cl = 1'b0;
		repeat (2) @(negedge clk);
		check(16'({switch_drive, standby, flag_pin, fault_status.cur_limit}), 16'h3);
		repeat (8) @(negedge clk);
		check(16'({switch_drive, fault_status.cur_limit}), 16'h2);
		// LED overcurrent in boost: qualify, skip, retry, recover
		boost_mode = 1'b1;
		cmp_raw.led_oc = 1'b1;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			while (!fault_status.led_oc && n < 100) begin
				@(negedge clk);
				n++;
			end
			check(16'(n >= 2 * SW_DIV && n <= 4 + 2 * SW_DIV), 16'h1);
			check(16'(obs[12:8]), 16'h0002);
			n = 0;
			while (fault_status.led_oc && n < 100) begin
				@(negedge clk);
				n++;
			end
			check(16'(n >= (RETRY - 1) * SW_DIV && n <= (RETRY + 1) * SW_DIV), 16'h1);
		end
		cmp_raw.led_oc = 1'b0;
		repeat (60) @(negedge clk);
		check(16'(obs), 16'h1900);
		// Reset in mid-run
		rst = 1'b1;
		repeat (3) @(negedge clk);
		check(16'(obs), 16'h0700);
		rst = 1'b0;
		repeat (5) @(negedge clk);
		check(16'(obs), 16'h1900);
		results();
	end
endmodule

`default_nettype wire
